// file: src/dpw_map.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the design files
`ifndef DPW_MAP_SVH
`define DPW_MAP_SVH
`define DPW_CTRL_ADDR 8'hAE
`define DPW_C0L_ADDR 8'hB1
`define DPW_C0H_ADDR 8'hB2
`define DPW_C1L_ADDR 8'hB3
`define DPW_C1H_ADDR 8'hB4
`define DPW_CTRL_RESET 8'h00
`define DPW_MODE_MSB 6
`define DPW_MODE_LSB 4
`define DPW_DIV_MSB 3
`define DPW_DIV_LSB 2
`define DPW_SRC_MSB 1
`define DPW_SRC_LSB 0
`define DPW_XTAL_DIV 4'hE
`endif

// file: src/dpw_pkg.sv
// types shared by the modulator files
// assumes the map header supplies the numeric constants
package dpw_pkg;
  typedef logic [7:0] dpw_byte_t;
  typedef logic [15:0] dpw_word_t;
  typedef enum logic [2:0] {
    DPW_MODE_OFF, DPW_MODE_SINGLE, DPW_MODE_TWIN8, DPW_MODE_TWIN16,
    DPW_MODE_NRZ, DPW_MODE_DUAL8, DPW_MODE_RZ, DPW_MODE_RSVD
  } dpw_mode_e;
endpackage : dpw_pkg

// file: src/dpw_tick_if.sv
// carries the count tick from the prescaler to the counter
// assumes one clock domain
`timescale 1ns/100ps
interface dpw_tick_if;
  logic restart;
  logic tick;
  logic [1:0] src_sel;
  logic [1:0] div_sel;
  modport pre (input restart, input src_sel, input div_sel, output tick);
  modport core (output restart, output src_sel, output div_sel, input tick);
endinterface : dpw_tick_if

// file: src/dpw_prescale.sv
// clock source select and prescaler producing a one-cycle count tick
// assumes source clocks are synchronous levels sampled by i_sys_clk
`timescale 1ns/100ps
`include "dpw_map.svh"
module dpw_prescale (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // source clocks
  input wire logic i_crystal_clock,
  input wire logic i_external_count_clock_pin,
  input wire logic i_pll_vco_clock,
  // link to core
  dpw_tick_if.pre tk
);
  logic [3:0] xdiv_reg;
  logic src_q_reg;
  logic xt_q_reg;
  logic [5:0] pre_reg;
  logic src_edge;
  logic xt_edge;
  logic src_level;
  logic [5:0] pre_max;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      xt_q_reg <= 1'b0;
      src_q_reg <= 1'b0;
    end else begin
      xt_q_reg <= i_crystal_clock;
      src_q_reg <= src_level;
    end
  end
  assign xt_edge = i_crystal_clock & ~xt_q_reg;

  // crystal divided by 15 is a rising edge every 15th crystal edge
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      xdiv_reg <= 4'h0;
    end else if (xt_edge) begin
      xdiv_reg <= (xdiv_reg == `DPW_XTAL_DIV) ? 4'h0 : xdiv_reg + 4'h1;
    end
  end

  always_comb begin
    case (tk.src_sel)
      2'b00: src_level = (xdiv_reg == 4'h0);
      2'b01: src_level = i_crystal_clock;
      2'b10: src_level = i_external_count_clock_pin;
      default: src_level = i_pll_vco_clock;
    endcase
  end
  assign src_edge = src_level & ~src_q_reg;

  always_comb begin
    case (tk.div_sel)
      2'b00: pre_max = 6'h00;
      2'b01: pre_max = 6'h03;
      2'b10: pre_max = 6'h0F;
      default: pre_max = 6'h3F;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pre_reg <= 6'h00;
    end else if (tk.restart) begin
      pre_reg <= 6'h00;
    end else if (src_edge) begin
      pre_reg <= (pre_reg >= pre_max) ? 6'h00 : pre_reg + 6'h01;
    end
  end
  assign tk.tick = src_edge && (pre_reg >= pre_max) && !tk.restart;
endmodule : dpw_prescale

// file: src/dpw_top.sv
// dual output pulse-width modulator, modes 0 to 2, with its registers
// assumes a single-cycle register write strobe from the core bus
// Functional notes
// - control write restarts the counter
// - low compare bytes staged in 16-bit modes
// - high write loads pair, applied next cycle
// - control bits 6..4 select the mode
// - control bits 3..2 set prescale 1/4/16/64
// - control bits 1..0 select count source
// - disabled mode leaves both pins undriven
// - mode 1 period from second compare pair
// - mode 1 duty from first compare pair
// - mode 2 period from second compare low
// - mode 2 first output falls at first low
// - mode 2 second output window high bytes
// - second high zero aligns both outputs
`timescale 1ns/100ps
`include "dpw_map.svh"
module dpw_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire dpw_pkg::dpw_byte_t i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  // count sources
  input wire logic i_crystal_clock,
  input wire logic i_external_count_clock_pin,
  input wire logic i_pll_vco_clock,
  // output pins
  output logic o_first_output_pin,
  output logic o_first_output_pin_oe,
  output logic o_second_output_pin,
  output logic o_second_output_pin_oe
);
  import dpw_pkg::*;

  dpw_byte_t ctrl_reg;
  dpw_byte_t stage0_reg;
  dpw_byte_t stage1_reg;
  dpw_word_t c0_reg;
  dpw_word_t c1_reg;
  dpw_word_t act0_reg;
  dpw_word_t act1_reg;
  logic pend_reg;
  dpw_word_t cnt_reg;
  logic out0_reg;
  logic out1_reg;
  dpw_mode_e mode;
  logic wide;
  logic wr_ctrl;
  logic wr_high;
  logic end_cyc;
  dpw_word_t cnt_next;
  logic [16:0] period;

  dpw_tick_if tk ();

  dpw_prescale u_pre (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_crystal_clock(i_crystal_clock),
    .i_external_count_clock_pin(i_external_count_clock_pin),
    .i_pll_vco_clock(i_pll_vco_clock),
    .tk(tk)
  );

  assign mode = dpw_mode_e'(ctrl_reg[`DPW_MODE_MSB:`DPW_MODE_LSB]);
  assign wide = (mode == DPW_MODE_SINGLE) || (mode == DPW_MODE_TWIN16) ||
                (mode == DPW_MODE_NRZ) || (mode == DPW_MODE_RZ);
  assign wr_ctrl = i_reg_wr && (i_reg_addr == `DPW_CTRL_ADDR);
  assign wr_high = i_reg_wr && ((i_reg_addr == `DPW_C0H_ADDR) ||
                   (i_reg_addr == `DPW_C1H_ADDR));
  assign tk.restart = wr_ctrl;
  assign tk.div_sel = ctrl_reg[`DPW_DIV_MSB:`DPW_DIV_LSB];
  assign tk.src_sel = ctrl_reg[`DPW_SRC_MSB:`DPW_SRC_LSB];

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg <= `DPW_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= {1'b0, i_reg_wdata[6:0]};
    end
  end

  // low bytes go to a hidden stage in wide modes, directly otherwise
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      stage0_reg <= 8'h00;
      stage1_reg <= 8'h00;
      c0_reg <= 16'h0000;
      c1_reg <= 16'h0000;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `DPW_C0L_ADDR: begin
          if (wide) stage0_reg <= i_reg_wdata;
          else c0_reg[7:0] <= i_reg_wdata;
        end
        `DPW_C1L_ADDR: begin
          if (wide) stage1_reg <= i_reg_wdata;
          else c1_reg[7:0] <= i_reg_wdata;
        end
        `DPW_C0H_ADDR: begin
          c0_reg[15:8] <= i_reg_wdata;
          if (wide) c0_reg[7:0] <= stage0_reg;
        end
        `DPW_C1H_ADDR: begin
          c1_reg[15:8] <= i_reg_wdata;
          if (wide) c1_reg[7:0] <= stage1_reg;
        end
        default: ;
      endcase
    end
  end

  // a high-byte write arms the swap; when it meets the end of a cycle
  // the set wins, so that pair lands at the next end of cycle instead
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pend_reg <= 1'b0;
    end else if (wr_high) begin
      pend_reg <= 1'b1;
    end else if (end_cyc) begin
      pend_reg <= 1'b0;
    end
  end

  // working copies change only at the end of a cycle, on a control write or in any mode that is not wide
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      act0_reg <= 16'h0000;
      act1_reg <= 16'h0000;
    end else if ((end_cyc && pend_reg) || wr_ctrl || !wide) begin
      act0_reg <= c0_reg;
      act1_reg <= c1_reg;
    end
  end

  // zero period in mode 1 means the full 65536 count
  always_comb begin
    case (mode)
      DPW_MODE_SINGLE: period = (act1_reg == 16'h0000) ? 17'h10000 :
                         {1'b0, act1_reg};
      DPW_MODE_TWIN8: period = {9'h000, act1_reg[7:0]} + 17'h00001;
      default: period = 17'h10000;
    endcase
  end

  // a cycle ends on the tick that would carry the counter to the period
  assign end_cyc = tk.tick && ({1'b0, cnt_reg} + 17'h00001 >= period);
  assign cnt_next = end_cyc ? 16'h0000 : cnt_reg + 16'h0001;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= 16'h0000;
    end else if (wr_ctrl || mode == DPW_MODE_OFF) begin
      cnt_reg <= 16'h0000;
    end else if (tk.tick) begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      out0_reg <= 1'b0;
      out1_reg <= 1'b0;
    end else begin
      case (mode)
        DPW_MODE_SINGLE: begin
          out0_reg <= (cnt_reg < act0_reg);
          out1_reg <= 1'b0;
        end
        DPW_MODE_TWIN8: begin
          if (cnt_reg[7:0] == 8'h00) out0_reg <= 1'b1;
          if (cnt_reg[7:0] == act0_reg[7:0]) out0_reg <= 1'b0;
          // equal bytes: go-low wins, giving an empty pulse
          if (cnt_reg[7:0] == act1_reg[15:8]) out1_reg <= 1'b1;
          if (cnt_reg[7:0] == act0_reg[15:8]) out1_reg <= 1'b0;
        end
        default: begin
          out0_reg <= 1'b0;
          out1_reg <= 1'b0;
        end
      endcase
    end
  end

  // modes 3 to 7 are not built here and leave the pins undriven as well
  assign o_first_output_pin_oe = (mode == DPW_MODE_SINGLE) ||
                                 (mode == DPW_MODE_TWIN8);
  assign o_second_output_pin_oe = (mode == DPW_MODE_TWIN8);
  assign o_first_output_pin = out0_reg;
  assign o_second_output_pin = out1_reg;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `DPW_CTRL_ADDR: o_reg_rdata <= ctrl_reg;
        `DPW_C0L_ADDR: o_reg_rdata <= c0_reg[7:0];
        `DPW_C0H_ADDR: o_reg_rdata <= c0_reg[15:8];
        `DPW_C1L_ADDR: o_reg_rdata <= c1_reg[7:0];
        `DPW_C1H_ADDR: o_reg_rdata <= c1_reg[15:8];
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  assign o_reg_hit = (i_reg_addr == `DPW_CTRL_ADDR) ||
                     (i_reg_addr == `DPW_C0L_ADDR) ||
                     (i_reg_addr == `DPW_C0H_ADDR) ||
                     (i_reg_addr == `DPW_C1L_ADDR) ||
                     (i_reg_addr == `DPW_C1H_ADDR);
endmodule : dpw_top

// file: bench/dpw_load.sv
// load on the two modulator pins, pulled low
// assumes pin and enable pairs straight from the top
`timescale 1ns/100ps
module dpw_load (
  // pins
  input wire logic i_pin0,
  input wire logic i_pin0_oe,
  input wire logic i_pin1,
  input wire logic i_pin1_oe,
  // levels seen
  output logic o_level0,
  output logic o_level1
);
  // pull-down, so an undriven pin never reads as a pulse
  assign o_level0 = i_pin0_oe & i_pin0;
  assign o_level1 = i_pin1_oe & i_pin1;
endmodule : dpw_load

// file: bench/dpw_checker.sv
// assertions on the modulator top ports
// assumes one clock, async active-high reset
`timescale 1ns/100ps
`include "dpw_map.svh"
module dpw_checker (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire dpw_pkg::dpw_byte_t i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_hit,
  // pins
  input wire logic o_first_output_pin,
  input wire logic o_first_output_pin_oe,
  input wire logic o_second_output_pin_oe
);
  import dpw_pkg::*;
  logic [7:0] ctrl_reg;
  logic [7:0] c0l_reg;
  dpw_mode_e mode;
  assign mode = dpw_mode_e'(ctrl_reg[6:4]);
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg <= 8'h00;
    end else if (i_reg_wr && i_reg_addr == `DPW_CTRL_ADDR) begin
      ctrl_reg <= i_reg_wdata;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      c0l_reg <= 8'h00;
    end else if (i_reg_wr && i_reg_addr == `DPW_C0L_ADDR) begin
      c0l_reg <= i_reg_wdata;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  off_undriven_a: assert property (mode == DPW_MODE_OFF |->
    !o_first_output_pin_oe && !o_second_output_pin_oe) else $error("oe on");
  off_low_a: assert property (mode == DPW_MODE_OFF &&
    $past(mode) == DPW_MODE_OFF |-> !o_first_output_pin) else $error("pin");
  twin_drive_a: assert property (mode == DPW_MODE_TWIN8 |->
    o_first_output_pin_oe && o_second_output_pin_oe) else $error("twin oe");
  single_drive_a: assert property (mode == DPW_MODE_SINGLE |->
    o_first_output_pin_oe && !o_second_output_pin_oe) else $error("one oe");
  ctrl_readback_a: assert property (i_reg_rd &&
    i_reg_addr == `DPW_CTRL_ADDR |=> o_reg_rdata == ($past(ctrl_reg) & 8'h7F))
    else $error("ctrl read");
  unmapped_zero_a: assert property (i_reg_rd && !o_reg_hit |=>
    o_reg_rdata == 8'h00) else $error("unmapped read");
  rdata_hold_a: assert property (!i_reg_rd |=>
    $stable(o_reg_rdata)) else $error("rdata moved");
  restart_high_a: assert property (i_reg_wr && c0l_reg != 8'h00 &&
    i_reg_addr == `DPW_CTRL_ADDR && i_reg_wdata[6:4] == 3'h2 |->
    ##[1:3] o_first_output_pin) else $error("no restart");
  cover property (mode == DPW_MODE_TWIN8 && o_first_output_pin);
  cover property (mode == DPW_MODE_SINGLE && $rose(o_first_output_pin));
  cover property (i_reg_rd && !o_reg_hit);
endmodule : dpw_checker

// file: bench/dual_output_pwm_modes_0_to_2_test.sv
// self-checking bench for the modulator, modes 0 to 2
// assumes the load model and checker are compiled first
`timescale 1ns/100ps
`include "dpw_map.svh"
module dual_output_pwm_modes_0_to_2_test;
  import dpw_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  dpw_byte_t i_reg_wdata = 8'h00;
  logic i_crystal_clock = 1'b0;
  logic i_external_count_clock_pin = 1'b0;
  logic i_pll_vco_clock = 1'b0;
  logic [7:0] o_reg_rdata;
  logic o_reg_hit, pin0, oe0, pin1, oe1, lvl0, lvl1;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  dpw_top DUT (.i_sys_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_hit, .i_crystal_clock,
    .i_external_count_clock_pin, .i_pll_vco_clock,
    .o_first_output_pin(pin0), .o_first_output_pin_oe(oe0),
    .o_second_output_pin(pin1), .o_second_output_pin_oe(oe1));
  dpw_load load (.i_pin0(pin0), .i_pin0_oe(oe0), .i_pin1(pin1),
    .i_pin1_oe(oe1), .o_level0(lvl0), .o_level1(lvl1));
  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // count sources: rising edges every 2, 4 and 8 system cycles
  always @(posedge i_sys_clk) begin
    #1 i_crystal_clock = ~i_crystal_clock;
    cycles++;
    i_external_count_clock_pin = cycles[1];
    i_pll_vco_clock = cycles[2];
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1 {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
    @(posedge i_sys_clk);
    #1 i_reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    #1 {i_reg_rd, i_reg_addr} = {1'b1, a};
    @(posedge i_sys_clk);
    #1 i_reg_rd = 1'b0;
    @(posedge i_sys_clk);
    #1 cmp(16'(o_reg_rdata), 16'(exp));
  endtask : rd
  // window must span whole periods so phase does not matter
  task automatic measure(input int e0, input int e1, input int n);
    int h0;
    int h1;
    h0 = 0;
    h1 = 0;
    repeat (40) @(posedge i_sys_clk);
    repeat (n) begin
      @(posedge i_sys_clk);
      #1 h0 += int'(lvl0);
      h1 += int'(lvl1);
    end
    #1 cmp(16'(h0), 16'(e0));
    cmp(16'(h1), 16'(e1));
  endtask : measure
  task automatic t_regs;
    rd(`DPW_CTRL_ADDR, 8'h00);
    cmp(16'(o_reg_hit), 16'h0001);
    rd(8'h55, 8'h00);
    cmp(16'(o_reg_hit), 16'h0000);
    measure(0, 0, 20);
    wr(`DPW_CTRL_ADDR, 8'hFF);
    rd(`DPW_CTRL_ADDR, 8'h7F);
    cmp(16'({oe0, oe1}), 16'h0000);
    wr(`DPW_CTRL_ADDR, 8'h00);
    measure(0, 0, 40);
  endtask : t_regs
  task automatic t_twin;
    wr(`DPW_CTRL_ADDR, 8'h21);
    wr(`DPW_C1L_ADDR, 8'h03);
    wr(`DPW_C0L_ADDR, 8'h01);
    wr(`DPW_C1H_ADDR, 8'h01);
    wr(`DPW_C0H_ADDR, 8'h03);
    measure(20, 40, 80);
    wr(`DPW_C1H_ADDR, 8'h00);
    measure(20, 60, 80);
    wr(`DPW_CTRL_ADDR, 8'h25);
    measure(80, 240, 320);
  endtask : t_twin
  // same twin pair as above, one source and prescale per step
  task automatic t_sources;
    wr(`DPW_CTRL_ADDR, 8'h20);
    measure(120, 360, 480);
    wr(`DPW_CTRL_ADDR, 8'h2A);
    measure(64, 192, 256);
    wr(`DPW_CTRL_ADDR, 8'h2F);
    measure(512, 1536, 2048);
  endtask : t_sources
  task automatic t_single;
    wr(`DPW_CTRL_ADDR, 8'h11);
    wr(`DPW_C1L_ADDR, 8'h09);
    wr(`DPW_C1H_ADDR, 8'h00);
    wr(`DPW_C0L_ADDR, 8'h03);
    wr(`DPW_C0H_ADDR, 8'h00);
    measure(60, 0, 180);
    wr(`DPW_C0L_ADDR, 8'h05);
    measure(60, 0, 180);
    rd(`DPW_C0L_ADDR, 8'h03);
    wr(`DPW_C0H_ADDR, 8'h00);
    measure(100, 0, 180);
  endtask : t_single
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge i_sys_clk);
    #1 i_reset = 1'b0;
    t_regs();
    t_twin();
    t_sources();
    t_single();
    tally_and_finish();
  end
endmodule : dual_output_pwm_modes_0_to_2_test
bind dpw_top dpw_checker chk (.i_sys_clk, .i_reset, .i_reg_wr, .i_reg_rd,
  .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_hit, .o_first_output_pin,
  .o_first_output_pin_oe, .o_second_output_pin_oe);
